// file: shared/crsq_defs.vh
/*
 reset sequencer constants: timer counts, clock rates, boot address.
 assumes inclusion by rtl files only; definitions, no logic.
*/
`ifndef CRSQ_DEFS_VH
`define CRSQ_DEFS_VH
`define CRSQ_CORE_HZ        10000000
`define CRSQ_SLOW_HZ        32768
`define CRSQ_SLOW_DIV       ((`CRSQ_CORE_HZ + `CRSQ_SLOW_HZ / 2) / `CRSQ_SLOW_HZ)
`define CRSQ_PIN_MIN_NS     2000
`define CRSQ_CLK_NS         100
`define CRSQ_PIN_MIN_CYC    ((`CRSQ_PIN_MIN_NS + `CRSQ_CLK_NS - 1) / `CRSQ_CLK_NS)
`define CRSQ_LONG_TICKS     4100
`define CRSQ_SHORT_TICKS    16
`define CRSQ_TIMER_W        13
`define CRSQ_BOOT_ADDR      16'h0000
`define CRSQ_ST_RUN         2'h0
`define CRSQ_ST_HOLD        2'h1
`define CRSQ_ST_TIME        2'h2
`endif

// file: rtl/crsq_tick_div.v
/*
 slow_32k_clock enable divider: one-cycle pulse every DIV core cycles.
 assumes a single core clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "crsq_defs.vh"
module crsq_tick_div #(
  parameter DIV = `CRSQ_SLOW_DIV
) (
  // clock and reset
  input  wire       CORE_CLK,
  input  wire       RST_N,
  // enable out
  output reg        TICK
);
  reg  [15:0] cnt;

  // keeps running through pin, software and debug resets, like the oscillator; only RST_N clears it
  always @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      cnt  <= 16'h0000;
      TICK <= 1'b0;
    end
    else if (cnt == DIV[15:0] - 16'h0001)
    begin
      cnt  <= 16'h0000;
      TICK <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + 16'h0001;
      TICK <= 1'b0;
    end
  end
endmodule // crsq_tick_div

// file: rtl/crsq_seq.v
/*
 chip reset sequencer: pin, software and debug core resets, with a
 reset timer in slow_32k_clock ticks releasing the processor to boot.
 assumes the pins are asynchronous to CORE_CLK; RST_N is power-on only.
*/
// Functional notes
// - pin high halts logic except oscillator, clock
// - pin reset forces register defaults
// - test mux, clock reset only with test pin
// - software bit resets same, shorter timer; code never clears test mux, clock from it
// - pin reset holds processor 4100 slow ticks
// - processor boots from address zero
// - debug reset clears processor core only
// - debug reset skips the reset timer
`timescale 1ns/1ps
`include "crsq_defs.vh"
module crsq_seq #(
  parameter LONG_TICKS  = `CRSQ_LONG_TICKS,
  parameter SHORT_TICKS = `CRSQ_SHORT_TICKS,
  parameter SLOW_DIV    = `CRSQ_SLOW_DIV
) (
  // clock and power-on reset
  input  wire        CORE_CLK,
  input  wire        RST_N,
  // reset sources
  input  wire        RESET_PIN,
  input  wire        TEST_PIN,
  input  wire        SOFT_RESET_REQ,
  input  wire        DEBUG_CORE_RST_N,
  // reset outputs
  output reg         DIGITAL_HALT,
  output reg         REG_DEFAULTS_RST,
  output reg         CPU_RST,
  output reg         CPU_CORE_RST,
  output reg         TEST_MUX_RST,
  output reg         RTC_RST,
  output reg  [15:0] BOOT_ADDR,
  output reg         SEQ_BUSY
);
  // idle levels of the synchronised pins: debug reset idles high
  localparam [2:0] SYNC_IDLE = 3'h4;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [12:0] timer;
  reg  [12:0] next_timer;
  reg  [12:0] limit;
  reg  [12:0] next_limit;
  reg         next_halt;
  reg         next_defaults;
  reg         next_cpu_rst;
  reg         next_core_rst;
  reg         next_test_mux_rst;
  reg         next_rtc_rst;
  reg  [15:0] next_boot_addr;
  reg         next_busy;

  wire [2:0]  pin_raw;
  wire [2:0]  pin_sync;
  wire        tick;
  wire        pin_on;
  wire        test_on;
  wire        full_on;
  wire        dbg_on;
  wire        expired;
  genvar      g;

  assign pin_raw = {DEBUG_CORE_RST_N, TEST_PIN, RESET_PIN};
  assign pin_on  = pin_sync[0];
  // test pin only matters while the reset pin is seen high
  assign test_on = pin_sync[1];
  assign dbg_on  = ~pin_sync[2];
  // software bit is on the core clock already, no flops needed
  assign full_on = pin_on | SOFT_RESET_REQ;
  // timer + 1 so the compare lands on the tick that ends the count
  assign expired = tick && (timer + 13'h0001 >= limit);

  crsq_tick_div #(
    .DIV     (SLOW_DIV)
  ) u_div (
    .CORE_CLK(CORE_CLK),
    .RST_N   (RST_N),
    .TICK    (tick)
  );

  // pins are asynchronous: two flops before use, one loop for all
  // reset parks each flop at its pin's rest level, no false edge
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_sync
      reg [1:0] ff;
      always @(posedge CORE_CLK)
      begin
        if (!RST_N)
          ff <= {2{SYNC_IDLE[g]}};
        else
          ff <= {ff[0], pin_raw[g]};
      end
      assign pin_sync[g] = ff[1];
    end
  endgenerate

  always @*
  begin
    next_state = state;
    case (state)
      `CRSQ_ST_RUN:
      begin
        if (full_on)
          next_state = `CRSQ_ST_HOLD;
      end
      `CRSQ_ST_HOLD:
      begin
        // waits for every full source to drop before timing
        if (!full_on)
          next_state = `CRSQ_ST_TIME;
      end
      `CRSQ_ST_TIME:
      begin
        if (full_on)
          next_state = `CRSQ_ST_HOLD;
        else if (expired)
          next_state = `CRSQ_ST_RUN;
      end
      default:
      begin
        next_state = `CRSQ_ST_HOLD;
      end
    endcase
  end

  // timer restarts whenever a full source is seen again
  always @*
  begin
    next_timer = timer;
    if (state != `CRSQ_ST_TIME || full_on)
      next_timer = 13'h0000;
    else if (tick)
      next_timer = timer + 13'h0001;
  end

  // pin wins in a cycle with both sources active; the last source seen sets the count
  always @*
  begin
    next_limit = limit;
    if (pin_on)
      next_limit = LONG_TICKS[12:0];
    else if (SOFT_RESET_REQ)
      next_limit = SHORT_TICKS[12:0];
  end

  // state, timer and limit each kept in flops of their own
  always @(posedge CORE_CLK)
  begin
    if (!RST_N)
      state <= `CRSQ_ST_HOLD;
    else
      state <= next_state;
  end

  always @(posedge CORE_CLK)
  begin
    if (!RST_N)
      timer <= 13'h0000;
    else
      timer <= next_timer;
  end

  // power-on starts a long count, as after a pin reset
  always @(posedge CORE_CLK)
  begin
    if (!RST_N)
      limit <= LONG_TICKS[12:0];
    else
      limit <= next_limit;
  end

  // outputs worked out ahead so that each port is a plain flop
  always @*
  begin
    next_halt         = full_on;
    next_defaults     = full_on;
    next_cpu_rst      = (next_state != `CRSQ_ST_RUN);
    // debug reset reaches the core only, no timer
    next_core_rst     = next_cpu_rst | dbg_on;
    // test mux and clock cleared only with the test pin held
    next_test_mux_rst = pin_on & test_on;
    next_rtc_rst      = pin_on & test_on;
    next_boot_addr    = `CRSQ_BOOT_ADDR;
    // busy marks the timed sequence, never the debug reset
    next_busy         = next_cpu_rst;
  end

  always @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      DIGITAL_HALT     <= 1'b1;
      REG_DEFAULTS_RST <= 1'b1;
      CPU_RST          <= 1'b1;
      CPU_CORE_RST     <= 1'b1;
      TEST_MUX_RST     <= 1'b1;
      RTC_RST          <= 1'b1;
      BOOT_ADDR        <= `CRSQ_BOOT_ADDR;
      SEQ_BUSY         <= 1'b1;
    end
    else
    begin
      DIGITAL_HALT     <= next_halt;
      REG_DEFAULTS_RST <= next_defaults;
      CPU_RST          <= next_cpu_rst;
      CPU_CORE_RST     <= next_core_rst;
      TEST_MUX_RST     <= next_test_mux_rst;
      RTC_RST          <= next_rtc_rst;
      // fetch restarts at zero once the core is let go
      BOOT_ADDR        <= next_boot_addr;
      SEQ_BUSY         <= next_busy;
    end
  end
endmodule // crsq_seq

// file: dv/crsq_board.sv
/* board reset source and host model: holds the reset pin for a set
 length and restarts the device watchdog at a steady rate.
 assumes requests arrive on the falling edge of the core clock. */
`timescale 1ns/1ps
module crsq_board (
  input  wire       CORE_CLK,
  input  wire       REQ,
  input  wire [7:0] LEN,
  output wire       RESET_PIN,
  output wire       WDOG_KICK
);
  reg [7:0] cnt = 8'h00;
  reg [5:0] kick_cnt = 6'h00;
  // host restarts the watchdog every 50 cycles, inside a 64 period
  always @(negedge CORE_CLK)
    kick_cnt <= (kick_cnt == 6'h31) ? 6'h00 : kick_cnt + 6'h01;
  assign WDOG_KICK = (kick_cnt == 6'h31);
  // 20 cycles at 100 ns is the 2 us floor
  always @(negedge CORE_CLK)
    if (REQ)
      cnt <= (LEN < 8'h14) ? 8'h14 : LEN;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  assign RESET_PIN = (cnt != 8'h00);
endmodule // crsq_board

// file: dv/crsq_chk_checker.sv
/* port assertions for the reset sequencer.
 assumes the bind below; short timer parameters in the bench. */
`timescale 1ns/1ps
module crsq_chk (
  input wire        CORE_CLK, RST_N, RESET_PIN, TEST_PIN, SOFT_RESET_REQ,
  input wire        DEBUG_CORE_RST_N, DIGITAL_HALT, REG_DEFAULTS_RST,
  input wire        CPU_RST, CPU_CORE_RST, TEST_MUX_RST, RTC_RST, SEQ_BUSY,
  input wire [15:0] BOOT_ADDR
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rel; $fell(DIGITAL_HALT); endsequence
  property p_halt; RESET_PIN |-> ##3 DIGITAL_HALT; endproperty
  a_halt: assert property (p_halt) else $error("halt");
  property p_dflt; RESET_PIN |-> ##3 REG_DEFAULTS_RST; endproperty
  a_dflt: assert property (p_dflt) else $error("dflt");
  property p_test; $rose(RTC_RST | TEST_MUX_RST) |-> $past(TEST_PIN, 3);
  endproperty
  a_test: assert property (p_test) else $error("test");
  property p_soft; SOFT_RESET_REQ |-> ##[1:2] CPU_RST; endproperty
  a_soft: assert property (p_soft) else $error("soft");
  property p_boot; BOOT_ADDR == 16'h0000; endproperty
  a_boot: assert property (p_boot) else $error("boot");
  property p_dbg; $fell(DEBUG_CORE_RST_N) |-> ##[2:3] CPU_CORE_RST;
  endproperty
  a_dbg: assert property (p_dbg) else $error("dbg");
  property p_skip; $rose(DEBUG_CORE_RST_N) && !SEQ_BUSY |-> ##4 !CPU_CORE_RST;
  endproperty
  a_skip: assert property (p_skip) else $error("skip");
  property p_hold; s_rel |-> CPU_RST[*2]; endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule // crsq_chk
bind crsq_seq crsq_chk i_chk (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .RESET_PIN(RESET_PIN),
  .TEST_PIN(TEST_PIN), .SOFT_RESET_REQ(SOFT_RESET_REQ),
  .DEBUG_CORE_RST_N(DEBUG_CORE_RST_N), .DIGITAL_HALT(DIGITAL_HALT),
  .REG_DEFAULTS_RST(REG_DEFAULTS_RST), .CPU_RST(CPU_RST),
  .CPU_CORE_RST(CPU_CORE_RST), .TEST_MUX_RST(TEST_MUX_RST),
  .RTC_RST(RTC_RST), .SEQ_BUSY(SEQ_BUSY), .BOOT_ADDR(BOOT_ADDR)
);

// file: dv/chip_reset_sequencer_tb.sv
/* bench: random pin, soft and debug resets.
 assumes short timers; the board model drives the pin. */
`timescale 1ns/1ps
module chip_reset_sequencer_tb;
  localparam LT = 8, ST = 2, DV = 2;
  logic CORE_CLK = 0, RST_N = 0, TEST_PIN = 0, SOFT_RESET_REQ = 0;
  logic DEBUG_CORE_RST_N = 1, REQ = 0;
  logic [7:0] LEN = 8'h14;
  logic [31:0] rs = 58789;
  integer n_fail = 0, check_count = 0, i, c;
  wire RESET_PIN, DIGITAL_HALT, REG_DEFAULTS_RST, CPU_RST, CPU_CORE_RST;
  wire TEST_MUX_RST, RTC_RST, SEQ_BUSY, WDOG_KICK;
  integer kick_gap = 0;
  wire [15:0] BOOT_ADDR;
  always #50 CORE_CLK = ~CORE_CLK;
  always @(negedge CORE_CLK)
    kick_gap <= WDOG_KICK ? 0 : kick_gap + 1;
  crsq_board i_brd (.CORE_CLK(CORE_CLK), .REQ(REQ), .LEN(LEN),
    .RESET_PIN(RESET_PIN), .WDOG_KICK(WDOG_KICK));
  crsq_seq #(.LONG_TICKS(LT), .SHORT_TICKS(ST), .SLOW_DIV(DV)) i_dut (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .RESET_PIN(RESET_PIN),
    .TEST_PIN(TEST_PIN), .SOFT_RESET_REQ(SOFT_RESET_REQ),
    .DEBUG_CORE_RST_N(DEBUG_CORE_RST_N), .DIGITAL_HALT(DIGITAL_HALT),
    .REG_DEFAULTS_RST(REG_DEFAULTS_RST), .CPU_RST(CPU_RST),
    .CPU_CORE_RST(CPU_CORE_RST), .TEST_MUX_RST(TEST_MUX_RST),
    .RTC_RST(RTC_RST), .BOOT_ADDR(BOOT_ADDR), .SEQ_BUSY(SEQ_BUSY));
  function [31:0] xs(input [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // slow tick phase is free, so allow one tick early and 6 cycles late
  function bit win(input integer n, t);
    return n >= (t - 1) * DV && n <= t * DV + 6;
  endfunction
  task chk(input [15:0] s, e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t %h %h", $time, s, e);
    end
  endtask
  task complete_run;
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  task rel(input integer t);
    for (c = 0; CPU_RST === 1'b1 && c < 40; c++)
      cyc(1);
    chk(win(c, t), 1'h1);
    if (c == 40)
      complete_run;
  endtask
  initial
  begin
    cyc(6);
    RST_N = 1;
    rel(LT);
    for (i = 0; i < 12; i++)
    begin
      rs = xs(rs);
      TEST_PIN = rs[0];
      LEN = 8'h14 + rs[3:1];
      if (rs[4])
      begin
        repeat (rs[5] + 1)
        begin
          cyc(6);
          REQ <= 1'b1;
          cyc(1);
          REQ <= 1'b0;
          cyc(LEN - 1);
          chk({DIGITAL_HALT, REG_DEFAULTS_RST, CPU_RST, SEQ_BUSY, RTC_RST,
            TEST_MUX_RST}, {4'hF, TEST_PIN, TEST_PIN});
          cyc(1);
        end
        rel(LT);
      end
      else
      begin
        SOFT_RESET_REQ = 1;
        cyc(LEN);
        chk({DIGITAL_HALT, REG_DEFAULTS_RST, CPU_RST}, 3'h7);
        SOFT_RESET_REQ = 0;
        rel(ST);
      end
      DEBUG_CORE_RST_N = 0;
      cyc(4 + rs[7:6]);
      chk({CPU_CORE_RST, CPU_RST, DIGITAL_HALT, SEQ_BUSY}, 4'h8);
      DEBUG_CORE_RST_N = 1;
      cyc(4);
      chk({CPU_CORE_RST, SEQ_BUSY}, 2'h0);
    end
    // corner: soft bit raised with the pin request, dropped while the pin is held, keeps the long count
    SOFT_RESET_REQ = 1;
    REQ <= 1'b1;
    cyc(1);
    REQ <= 1'b0;
    cyc(8'h14);
    SOFT_RESET_REQ = 0;
    cyc(1);
    rel(LT);
    chk(kick_gap < 64, 1'h1);
    complete_run;
  end
endmodule // chip_reset_sequencer_tb
